// ===== src/tws_top.sv
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "tws_regs.svh"

module tws_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tws_pkg::tws_pin_t bus_i,
  output tws_pkg::tws_pin_t bus_o,
  output tws_pkg::tws_pin_t bus_oe,
  input wire logic low_power,
  output logic irq,
  output logic wake
);

  tws_pkg::tws_core_t q_r; // registered state
  tws_pkg::tws_core_t q_nxt; // next state
  tws_pkg::tws_pin_t pin_f; // synced, filtered lines
  logic tick; // quarter bit enable
  logic div_run; // master timing active
  logic [7:0] div_eff; // divider clamped to max rate
  logic wr; // apb write access
  logic setup; // apb setup phase
  logic mapped; // address hits a register
  logic cmd_wr; // command register written
  logic cmd_start;
  logic cmd_stop;
  logic cmd_write;
  logic cmd_read;
  logic start_det; // sda falls while scl high
  logic stop_det; // sda rises while scl high
  logic scl_rise;
  logic scl_fall;
  logic is_slave; // in a slave state
  logic is_master; // in a master state
  logic adv; // master phase may advance

  tws_filter #(
    .CNT_W(3),
    .LEN(`TWS_FILT_CYC)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .enable(q_r.ctrl.filt_en && !low_power),
    .pin_i(bus_i),
    .pin_f(pin_f)
  );

  assign div_eff = (q_r.div < 8'(`TWS_DIV_MIN)) ? 8'(`TWS_DIV_MIN) : q_r.div;
  assign div_run = (q_r.st == tws_pkg::ST_MSTART) ||
                   (q_r.st == tws_pkg::ST_MBIT) ||
                   (q_r.st == tws_pkg::ST_MSTOP);

  tws_div #(
    .DIV_W(`TWS_DIV_W)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(div_run),
    .div(div_eff),
    .tick(tick)
  );

  // apb decode, zero wait states
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `TWS_OFF_STATE);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = q_r.prdata;
  assign cmd_wr = wr && (paddr == `TWS_OFF_CMD);
  assign cmd_start = cmd_wr && pwdata[`TWS_CMD_START];
  assign cmd_stop = cmd_wr && pwdata[`TWS_CMD_STOP];
  assign cmd_write = cmd_wr && pwdata[`TWS_CMD_WRITE];
  assign cmd_read = cmd_wr && pwdata[`TWS_CMD_READ];

  // bus events from the filtered lines
  assign start_det = pin_f.scl && q_r.scl_prev && q_r.sda_prev && !pin_f.sda;
  assign stop_det = pin_f.scl && q_r.scl_prev && !q_r.sda_prev && pin_f.sda;
  assign scl_rise = pin_f.scl && !q_r.scl_prev;
  assign scl_fall = !pin_f.scl && q_r.scl_prev;
  assign is_slave = (q_r.st == tws_pkg::ST_SBIT) ||
                    (q_r.st == tws_pkg::ST_SWAIT);
  assign is_master = div_run || (q_r.st == tws_pkg::ST_MHOLD);
  // wait while another device holds scl low
  // released scl must read high before the high phase acts
  assign adv = tick && ((q_r.phase != 2'd2) || pin_f.scl);

  // open drain: drive low only, enable while pulling
  assign bus_o = '{scl: 1'b0, sda: 1'b0};
  assign bus_oe = '{scl: q_r.scl_low, sda: q_r.sda_low};

  // level interrupt from unmasked sticky flags
  assign irq = |(q_r.status & q_r.mask);
  assign wake = q_r.wake;

  // registers, bus tracking and the bit sequencer
  always_comb begin
    tws_pkg::tws_evt_t ev;
    ev = '0;
    q_nxt = q_r;
    q_nxt.scl_prev = pin_f.scl;
    q_nxt.sda_prev = pin_f.sda;

    // register writes
    if (wr) begin
      unique case (paddr)
        `TWS_OFF_CTRL: q_nxt.ctrl = pwdata[`TWS_CTRL_W-1:0];
        `TWS_OFF_OWN_ADDR: q_nxt.own_addr = pwdata[`TWS_ADDR_W-1:0];
        `TWS_OFF_DIV: q_nxt.div = pwdata[`TWS_DIV_W-1:0];
        `TWS_OFF_DATA: q_nxt.tx = pwdata[7:0];
        `TWS_OFF_MASK: q_nxt.mask = pwdata[`TWS_EVT_W-1:0];
        default: begin
        end
      endcase
    end

    // read data captured in the setup phase
    if (setup) begin
      unique case (paddr)
        `TWS_OFF_CTRL: q_nxt.prdata = 32'(q_r.ctrl);
        `TWS_OFF_OWN_ADDR: q_nxt.prdata = 32'(q_r.own_addr);
        `TWS_OFF_DIV: q_nxt.prdata = 32'(q_r.div);
        `TWS_OFF_DATA: q_nxt.prdata = 32'(q_r.rx);
        `TWS_OFF_STATUS: q_nxt.prdata = 32'(q_r.status);
        `TWS_OFF_MASK: q_nxt.prdata = 32'(q_r.mask);
        `TWS_OFF_STATE: q_nxt.prdata = 32'({q_r.bus_busy, q_r.rx_ack,
                                           q_r.slave_tx, is_slave,
                                           is_master});
        default: q_nxt.prdata = 32'h0000_0000;
      endcase
    end

    // bus busy between start and stop
    if (start_det) begin
      q_nxt.bus_busy = 1'b1;
    end else if (stop_det) begin
      q_nxt.bus_busy = 1'b0;
    end

    unique case (q_r.st)
      tws_pkg::ST_IDLE: begin
        q_nxt.scl_low = 1'b0;
        q_nxt.sda_low = 1'b0;
        if (cmd_start && q_r.ctrl.master_en) begin
          if (q_r.bus_busy) begin
            ev.arb = 1'b1;
          end else begin
            q_nxt.st = tws_pkg::ST_MSTART;
            q_nxt.phase = 2'd0;
          end
        // slave starts only on a start condition
        end else if (start_det && q_r.ctrl.slave_en) begin
          q_nxt.st = tws_pkg::ST_SBIT;
          // first scl fall closes the start, not a bit
          q_nxt.bitcnt = 4'hf;
          q_nxt.addr_phase = 1'b1;
          q_nxt.slave_tx = 1'b0;
        end
      end

      // same sequence serves start and repeated start
      tws_pkg::ST_MSTART: begin
        if (adv) begin
          q_nxt.phase = q_r.phase + 2'd1;
          unique case (q_r.phase)
            2'd0: q_nxt.sda_low = 1'b0;
            2'd1: q_nxt.scl_low = 1'b0;
            2'd2: q_nxt.sda_low = 1'b1;
            2'd3: begin
              q_nxt.scl_low = 1'b1;
              q_nxt.st = tws_pkg::ST_MHOLD;
              ev.done = 1'b1;
            end
          endcase
        end
      end

      // master owns the bus, scl held low for the cpu
      tws_pkg::ST_MHOLD: begin
        q_nxt.scl_low = 1'b1;
        if (cmd_start) begin
          q_nxt.st = tws_pkg::ST_MSTART;
          q_nxt.phase = 2'd0;
        end else if (cmd_stop) begin
          q_nxt.st = tws_pkg::ST_MSTOP;
          q_nxt.phase = 2'd0;
        end else if (cmd_write || cmd_read) begin
          // address byte is a write of addr and direction
          q_nxt.st = tws_pkg::ST_MBIT;
          q_nxt.phase = 2'd0;
          q_nxt.bitcnt = 4'd0;
          q_nxt.shift = q_r.tx;
          q_nxt.rd_mode = cmd_read;
        end
      end

      // master transmit or receive, one bit per four ticks
      tws_pkg::ST_MBIT: begin
        if (adv) begin
          q_nxt.phase = q_r.phase + 2'd1;
          unique case (q_r.phase)
            2'd0: begin
              // master acks a read byte during the ninth clock
              if (q_r.bitcnt == 4'd8) begin
                q_nxt.sda_low = q_r.rd_mode && q_r.ctrl.ack_en;
              end else begin
                q_nxt.sda_low = !q_r.rd_mode && !q_r.shift[7];
              end
            end
            2'd1: q_nxt.scl_low = 1'b0;
            2'd2: begin
              if (q_r.bitcnt == 4'd8) begin
                q_nxt.rx_ack = pin_f.sda;
              end else begin
                q_nxt.shift = {q_r.shift[6:0], pin_f.sda};
              end
              // released a one but the line reads low
              if (!q_r.rd_mode && !q_r.sda_low && !pin_f.sda &&
                  (q_r.bitcnt != 4'd8)) begin
                ev.arb = 1'b1;
                q_nxt.st = tws_pkg::ST_IDLE;
                q_nxt.scl_low = 1'b0;
                q_nxt.sda_low = 1'b0;
              end
            end
            2'd3: begin
              q_nxt.scl_low = 1'b1;
              if (q_r.bitcnt == 4'd8) begin
                q_nxt.st = tws_pkg::ST_MHOLD;
                q_nxt.rx = q_r.shift;
                q_nxt.sda_low = 1'b0;
                ev.done = 1'b1;
              end else begin
                q_nxt.bitcnt = q_r.bitcnt + 4'd1;
              end
            end
          endcase
        end
      end

      // stop: sda rises while scl high
      tws_pkg::ST_MSTOP: begin
        if (adv) begin
          q_nxt.phase = q_r.phase + 2'd1;
          unique case (q_r.phase)
            2'd0: q_nxt.sda_low = 1'b1;
            2'd1: q_nxt.scl_low = 1'b0;
            2'd2: q_nxt.sda_low = 1'b0;
            2'd3: begin
              q_nxt.st = tws_pkg::ST_IDLE;
              ev.done = 1'b1;
            end
          endcase
        end
      end

      // slave follows the remote clock edges
      tws_pkg::ST_SBIT: begin
        if (scl_rise) begin
          if (q_r.bitcnt == 4'd8) begin
            q_nxt.rx_ack = pin_f.sda;
          end else begin
            q_nxt.shift = {q_r.shift[6:0], pin_f.sda};
          end
        end else if (scl_fall) begin
          if (q_r.bitcnt == 4'd7) begin
            q_nxt.bitcnt = 4'd8;
            if (q_r.addr_phase) begin
              // seven bits only, no 10-bit match
              if (q_r.shift[7:1] == q_r.own_addr) begin
                ev.addr = 1'b1;
                q_nxt.sda_low = 1'b1;
                q_nxt.slave_tx = q_r.shift[0];
              end else begin
                q_nxt.st = tws_pkg::ST_IDLE;
                q_nxt.sda_low = 1'b0;
              end
            end else if (!q_r.slave_tx) begin
              q_nxt.rx = q_r.shift;
              q_nxt.sda_low = q_r.ctrl.ack_en;
              ev.done = 1'b1;
            end else begin
              q_nxt.sda_low = 1'b0;
              ev.done = 1'b1;
            end
          end else if (q_r.bitcnt == 4'd8) begin
            q_nxt.sda_low = 1'b0;
            // refused read: wait for stop or restart
            if (q_r.slave_tx && !q_r.addr_phase && q_r.rx_ack) begin
              q_nxt.st = tws_pkg::ST_IDLE;
            end else begin
              q_nxt.st = tws_pkg::ST_SWAIT;
              q_nxt.scl_low = 1'b1;
              q_nxt.addr_phase = 1'b0;
            end
          end else begin
            q_nxt.bitcnt = q_r.bitcnt + 4'd1;
            q_nxt.sda_low = q_r.slave_tx && !q_r.shift[7];
          end
        end
      end

      // slave stretches scl until the cpu continues
      tws_pkg::ST_SWAIT: begin
        q_nxt.scl_low = 1'b1;
        if (cmd_write || cmd_read) begin
          q_nxt.st = tws_pkg::ST_SBIT;
          q_nxt.scl_low = 1'b0;
          q_nxt.bitcnt = 4'd0;
          q_nxt.shift = q_r.tx;
          q_nxt.sda_low = q_r.slave_tx && !q_r.tx[7];
        end
      end
    endcase

    // repeated start restarts the slave address phase
    if (start_det && q_r.ctrl.slave_en && is_slave) begin
      q_nxt.st = tws_pkg::ST_SBIT;
      q_nxt.bitcnt = 4'hf;
      q_nxt.addr_phase = 1'b1;
      q_nxt.slave_tx = 1'b0;
      q_nxt.scl_low = 1'b0;
      q_nxt.sda_low = 1'b0;
    end else if (stop_det && is_slave) begin
      q_nxt.st = tws_pkg::ST_IDLE;
      q_nxt.scl_low = 1'b0;
      q_nxt.sda_low = 1'b0;
    end

    // sticky flags, a new event wins over the clear
    ev.stop = stop_det;
    if (wr && (paddr == `TWS_OFF_STATUS)) begin
      q_nxt.status = (q_r.status & ~pwdata[`TWS_EVT_W-1:0]) | ev;
    end else begin
      q_nxt.status = q_r.status | ev;
    end

    // wake on address match while in low power
    if (!low_power) begin
      q_nxt.wake = 1'b0;
    end else if (ev.addr && q_r.ctrl.wake_en) begin
      q_nxt.wake = 1'b1;
    end
  end

  // all core state in one register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
      q_r.st <= tws_pkg::ST_IDLE;
      q_r.own_addr <= `TWS_OWN_ADDR_RST;
      q_r.div <= 8'(`TWS_DIV_RST);
      q_r.ctrl <= `TWS_CTRL_RST;
      q_r.status <= `TWS_EVT_RST;
      q_r.mask <= `TWS_EVT_RST;
      q_r.scl_prev <= 1'b1;
      q_r.sda_prev <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule

// ===== src/tws_regs.svh
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

// register byte offsets, one aligned 32-bit word each
`define TWS_OFF_CTRL 8'h00
`define TWS_OFF_OWN_ADDR 8'h04
`define TWS_OFF_DIV 8'h08
`define TWS_OFF_CMD 8'h0c
`define TWS_OFF_DATA 8'h10
`define TWS_OFF_STATUS 8'h14
`define TWS_OFF_MASK 8'h18
`define TWS_OFF_STATE 8'h1c

// command register bit positions (write only, self clearing)
`define TWS_CMD_START 0
`define TWS_CMD_STOP 1
`define TWS_CMD_WRITE 2
`define TWS_CMD_READ 3

// field widths
`define TWS_CTRL_W 5
`define TWS_EVT_W 4
`define TWS_ADDR_W 7
`define TWS_DIV_W 8

// reset values
`define TWS_CTRL_RST 5'h00
`define TWS_OWN_ADDR_RST 7'h00
`define TWS_EVT_RST 4'h0

// timing: system clock rate, glitch width, bit rates
`define TWS_CLK_KHZ 25000
`define TWS_FILT_NS 50
`define TWS_FILT_CYC ((`TWS_FILT_NS * `TWS_CLK_KHZ + 999999) / 1000000)
`define TWS_MAX_KBPS 1000
`define TWS_DIV_MIN ((`TWS_CLK_KHZ + 4 * `TWS_MAX_KBPS - 1) / (4 * `TWS_MAX_KBPS) - 1)
`define TWS_RST_KBPS 100
`define TWS_DIV_RST (`TWS_CLK_KHZ / (4 * `TWS_RST_KBPS) - 1)

`endif

// ===== src/tws_pkg.sv
package tws_pkg;

  // controller sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MSTART,
    ST_MHOLD,
    ST_MBIT,
    ST_MSTOP,
    ST_SBIT,
    ST_SWAIT
  } tws_state_t;

  // the two bus lines travel together
  typedef struct packed {
    logic scl;
    logic sda;
  } tws_pin_t;

  // control register layout, slave_en in bit 0
  typedef struct packed {
    logic wake_en;
    logic ack_en;
    logic filt_en;
    logic master_en;
    logic slave_en;
  } tws_ctrl_t;

  // sticky event layout, done in bit 0
  typedef struct packed {
    logic arb;
    logic stop;
    logic addr;
    logic done;
  } tws_evt_t;

  // whole state of the controller core
  typedef struct packed {
    tws_state_t st;
    logic [1:0] phase;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [6:0] own_addr;
    logic [7:0] div;
    tws_ctrl_t ctrl;
    tws_evt_t status;
    tws_evt_t mask;
    logic scl_low;
    logic sda_low;
    logic rd_mode;
    logic addr_phase;
    logic slave_tx;
    logic rx_ack;
    logic bus_busy;
    logic scl_prev;
    logic sda_prev;
    logic wake;
    logic [31:0] prdata;
  } tws_core_t;

endpackage

// ===== src/tws_filter.sv
`timescale 1ns/1ps

module tws_filter #(
  parameter int CNT_W = 3,
  parameter int LEN = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire tws_pkg::tws_pin_t pin_i,
  output tws_pkg::tws_pin_t pin_f
);

  // two sync stages, filtered output and a stability counter per line
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] out;
    logic [1:0][CNT_W-1:0] cnt;
  } tws_filt_state_t;

  tws_filt_state_t q_r;
  tws_filt_state_t q_nxt;

  // per line: follow the synced level once it held LEN cycles
  always_comb begin
    q_nxt = q_r;
    q_nxt.sync1 = {pin_i.scl, pin_i.sda};
    q_nxt.sync2 = q_r.sync1;
    for (int i = 0; i < 2; i++) begin
      if (!enable) begin
        // disabled or sleeping: no filter, synced level passes
        q_nxt.out[i] = q_r.sync2[i];
        q_nxt.cnt[i] = '0;
      end else if (q_r.sync2[i] == q_r.out[i]) begin
        q_nxt.cnt[i] = '0;
      end else if (q_r.cnt[i] == CNT_W'(LEN - 1)) begin
        q_nxt.out[i] = q_r.sync2[i];
        q_nxt.cnt[i] = '0;
      end else begin
        q_nxt.cnt[i] = q_r.cnt[i] + CNT_W'(1);
      end
    end
  end

  // lines idle high, so reset to released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '{sync1: 2'h3, sync2: 2'h3, out: 2'h3, cnt: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign pin_f.scl = q_r.out[1];
  assign pin_f.sda = q_r.out[0];

endmodule

// ===== src/tws_div.sv
`timescale 1ns/1ps

module tws_div #(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [DIV_W-1:0] div,
  output logic tick
);

  // divider count, restarts whenever run drops
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } tws_div_state_t;

  tws_div_state_t q_r;
  tws_div_state_t q_nxt;

  // one enable pulse every div+1 cycles
  assign tick = run && (q_r.cnt == div);

  // count up, wrap on tick
  always_comb begin
    q_nxt = q_r;
    if (!run || tick) begin
      q_nxt.cnt = '0;
    end else begin
      q_nxt.cnt = q_r.cnt + DIV_W'(1);
    end
  end

  // register the divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule

// ===== tb/tws_properties.sv
`timescale 1ns/1ps
// port-level checks of the two-wire controller
module tws_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire tws_pkg::tws_pin_t bus_i,
  input wire tws_pkg::tws_pin_t bus_o,
  input wire tws_pkg::tws_pin_t bus_oe,
  input wire logic low_power,
  input wire logic irq,
  input wire logic wake
);
  // one clock domain, one reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // offsets outside the word-aligned map
  logic bad_addr;
  assign bad_addr = (paddr > 8'h1c) || (paddr[1:0] != 2'h0);
  apb_ready_a: assert property (
    psel && penable |-> pready) else $error("pready low in access");
  map_error_a: assert property (
    pslverr == (psel && penable && bad_addr))
    else $error("pslverr not tied to unmapped access");
  bad_read_a: assert property (
    psel && penable && !pwrite && bad_addr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  pull_only_a: assert property (
    bus_o == 2'h0) else $error("bus driven high");
  scl_release_a: assert property (
    $fell(bus_oe.scl) |-> !bus_oe.scl [*7])
    else $error("clock pulled again too soon");
  wake_cause_a: assert property (
    $rose(wake) |-> $past(low_power)) else $error("wake while awake");
  wake_clear_a: assert property (
    !low_power [*2] |-> !wake) else $error("wake stays after waking");
  mask_gate_a: assert property (
    psel && penable && pwrite && paddr == 8'h18 && pwdata[3:0] == 4'h0
    |=> !irq) else $error("irq with all masked");
endmodule

bind tws_top tws_properties chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bus_i(bus_i), .bus_o(bus_o), .bus_oe(bus_oe), .low_power(low_power),
  .irq(irq), .wake(wake));

// ===== tb/tws_slave_model.sv
`timescale 1ns/1ps
// behavioural slave on the far side of the two-wire bus
module tws_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [7:0] TXB = 8'h5e
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  output logic scl_low,
  output logic sda_low
);
  logic [7:0] sh, last_rx; // shifter, last written byte
  int n; // rising clocks in this byte
  logic sel, rd, in_addr;
  initial begin
    {scl_low, sda_low, sel, rd, in_addr} = 5'h00;
    n = 0; sh = 8'h00; last_rx = 8'h00;
  end
  // start or repeated start opens an address byte
  always @(negedge sda) if (scl === 1'b1) begin
    n = 0; in_addr = 1'b1; sel = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    sel = 1'b0; in_addr = 1'b0;
  end
  // msb first on rising clock, nack ends a read
  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    else if (rd && sda) sel = 1'b0;
    n = n + 1;
  end
  // ack slot or next data bit after falling clock
  always @(negedge scl) begin
    sda_low = 1'b0;
    if (n == 8 && in_addr) begin
      sel = sh[7:1] == ADDR; rd = sh[0]; in_addr = 1'b0; sda_low = sel;
    end else if (n == 8 && sel && !rd) begin
      last_rx = sh; sda_low = 1'b1;
    end else if (n == 9) n = 0;
    if (sel && rd && n < 8) sda_low = !TXB[7 - n];
  end
  // slow slave holds the clock low
  always @(negedge scl) if (stretch) begin
    scl_low = 1'b1;
    #960 scl_low = 1'b0;
  end
endmodule

// ===== tb/tws_top_tb_top.sv
`timescale 1ns/1ps
`include "tws_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("ERROR %s exp %h got %h", nm, e, g); end end
// bench: apb master, open-drain wires, slave model
module tws_top_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic low_power = 0, stretch = 0, err, m_scl_low, m_sda_low;
  logic tb_scl_low = 0, tb_sda_low = 0, ack_seen; // far-side master
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, wake;
  tws_pkg::tws_pin_t bus_i, bus_o, bus_oe;
  int miscompares = 0, samples_checked = 0;
  localparam logic [6:0] SLV = 7'h2a;
  localparam logic [7:0] RDB = 8'h5e;
  logic [7:0] bad [2] = '{8'h20, 8'h06};
  always #20 pclk = ~pclk;
  // wired-and lines with pull-ups
  assign bus_i.scl = ~(bus_oe.scl | m_scl_low | tb_scl_low);
  assign bus_i.sda = ~(bus_oe.sda | m_sda_low | tb_sda_low);
  tws_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_i(bus_i),
    .bus_o(bus_o), .bus_oe(bus_oe), .low_power(low_power), .irq(irq),
    .wake(wake));
  tws_slave_model #(.ADDR(SLV), .TXB(RDB)) slv_u (.scl(bus_i.scl),
    .sda(bus_i.sda), .stretch(stretch), .scl_low(m_scl_low),
    .sda_low(m_sda_low));
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // command, wait for irq, check and clear status
  task op(input int b, input logic [31:0] exp);
    int i;
    apb(1'b1, `TWS_OFF_CMD, 32'h1 << b);
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge pclk);
    repeat (40) @(posedge pclk);
    `CHK("irq_set", 1'b1, irq)
    apb(1'b0, `TWS_OFF_STATUS, 32'h0);
    `CHK("status", exp, rd)
    apb(1'b1, `TWS_OFF_STATUS, rd);
    apb(1'b0, `TWS_OFF_STATUS, 32'h0);
    `CHK("status_clr", 32'h0, rd)
    `CHK("irq_clr", 1'b0, irq)
  endtask
  // far-side master: start, one byte msb first, ack into ack_seen
  task bb_byte(input logic [7:0] b);
    tb_sda_low <= 1'b1;
    repeat (20) @(posedge pclk);
    for (int j = 7; j >= -1; j--) begin
      tb_scl_low <= 1'b1;
      repeat (20) @(posedge pclk);
      tb_sda_low <= (j >= 0) ? !b[j & 7] : 1'b0;
      repeat (20) @(posedge pclk);
      tb_scl_low <= 1'b0;
      repeat (20) @(posedge pclk);
      if (j < 0) ack_seen = bus_i.sda;
    end
    tb_scl_low <= 1'b1;
  endtask
  // far-side master: stop from a low clock
  task bb_stop;
    tb_sda_low <= 1'b1;
    repeat (20) @(posedge pclk);
    tb_scl_low <= 1'b0;
    repeat (20) @(posedge pclk);
    tb_sda_low <= 1'b0;
    repeat (20) @(posedge pclk);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog well past the expected run
  initial begin
    #2400000;
    miscompares++;
    stop_test;
  end
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) if (i != 3) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      `CHK("reset", (i == 2) ? 32'h3d : 32'h0, rd)
    end
    apb(1'b1, `TWS_OFF_OWN_ADDR, 32'hffff_ffff);
    apb(1'b0, `TWS_OFF_OWN_ADDR, 32'h0);
    `CHK("own_addr", 32'h7f, rd)
    apb(1'b1, `TWS_OFF_STATE, 32'h1f);
    apb(1'b0, `TWS_OFF_STATE, 32'h0);
    `CHK("state_ro", 32'h0, rd)
    foreach (bad[k]) begin
      apb(1'b1, bad[k], 32'h1);
      `CHK("wr_err", 1'b1, err)
      apb(1'b0, bad[k], 32'h0);
      `CHK("rd_err", {1'b1, 32'h0}, {err, rd})
    end
    apb(1'b1, `TWS_OFF_CTRL, 32'h06);
    apb(1'b1, `TWS_OFF_DIV, 32'h6);
    apb(1'b1, `TWS_OFF_MASK, 32'hf);
    stretch <= 1'b1;
    op(`TWS_CMD_START, 32'h1);
    apb(1'b1, `TWS_OFF_DATA, {24'h0, SLV, 1'b0});
    op(`TWS_CMD_WRITE, 32'h1);
    apb(1'b0, `TWS_OFF_STATE, 32'h0);
    `CHK("addr_ack", 32'h11, rd)
    apb(1'b1, `TWS_OFF_DATA, 32'hc3);
    op(`TWS_CMD_WRITE, 32'h1);
    `CHK("slave_rx", 8'hc3, slv_u.last_rx)
    stretch <= 1'b0;
    op(`TWS_CMD_START, 32'h1);
    apb(1'b1, `TWS_OFF_DATA, {24'h0, SLV, 1'b1});
    op(`TWS_CMD_WRITE, 32'h1);
    op(`TWS_CMD_READ, 32'h1);
    apb(1'b0, `TWS_OFF_DATA, 32'h0);
    `CHK("master_rx", {24'h0, RDB}, rd)
    op(`TWS_CMD_STOP, 32'h5);
    op(`TWS_CMD_START, 32'h1);
    apb(1'b1, `TWS_OFF_DATA, 32'h2a);
    op(`TWS_CMD_WRITE, 32'h1);
    apb(1'b0, `TWS_OFF_STATE, 32'h0);
    `CHK("addr_nack", 32'h19, rd)
    op(`TWS_CMD_STOP, 32'h5);
    apb(1'b1, `TWS_OFF_MASK, 32'h0);
    apb(1'b1, `TWS_OFF_CMD, 32'h1);
    rd = 32'h0;
    for (int i = 0; i < 60 && rd === 32'h0; i++) begin
      repeat (10) @(posedge pclk);
      apb(1'b0, `TWS_OFF_STATUS, 32'h0);
    end
    `CHK("poll_done", 32'h1, rd)
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, `TWS_OFF_STATUS, 32'hf);
    apb(1'b1, `TWS_OFF_MASK, 32'hf);
    op(`TWS_CMD_STOP, 32'h5);
    low_power <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK("no_wake", 1'b0, wake)
    low_power <= 1'b0;
    // foreign start ignored while the slave role is off
    apb(1'b1, `TWS_OFF_CTRL, 32'h02);
    apb(1'b1, `TWS_OFF_OWN_ADDR, 32'h33);
    bb_byte({7'h33, 1'b0});
    apb(1'b0, `TWS_OFF_STATUS, 32'h0);
    `CHK("no_start_flag", {1'b1, 32'h0}, {ack_seen, rd})
    bb_stop;
    apb(1'b1, `TWS_OFF_STATUS, 32'hf);
    // address match while asleep acks, flags and wakes
    apb(1'b1, `TWS_OFF_CTRL, 32'h11);
    low_power <= 1'b1;
    bb_byte({7'h33, 1'b0});
    `CHK("slave_ack", 1'b0, ack_seen)
    `CHK("wake_set", 1'b1, wake)
    apb(1'b0, `TWS_OFF_STATUS, 32'h0);
    `CHK("addr_match", 32'h2, rd)
    apb(1'b0, `TWS_OFF_STATE, 32'h0);
    `CHK("slave_hold", 32'h12, rd)
    apb(1'b1, `TWS_OFF_CMD, 32'h4);
    bb_stop;
    low_power <= 1'b0;
    repeat (5) @(posedge pclk);
    `CHK("wake_clr", 1'b0, wake)
    stop_test;
  end
endmodule
